// File: core/psram_host_map.vh
// timing constants for the host-side pseudo-static ram access controller
// assumes a 20 MHz controller clock; counts are whole clock cycles
`ifndef PSRAM_HOST_MAP_VH
`define PSRAM_HOST_MAP_VH

`define CLK_PERIOD_NS     50
`define ADDR_W            20
`define DATA_W            16
// device figures in their own unit
`define T_RC_NS           80
`define T_CE_NS           60
`define T_OE_NS           35
`define T_AA_NS           60
`define T_CLOL_NS         25
`define T_OLAH_NS         45
`define T_WC_NS           80
`define T_AS_SUM_NS       60
`define T_WP_NS           45
`define T_WR_NS           20
`define T_OHCL_NS         10
`define T_CSP_NS          10
`define T_C2LP_NS         80
`define T_CHS_NS          10
`define T_CHH_US          350
`define T_CHOX_NS         10
// minimum figures rounded up to cycles, never below one
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define C_READ     `CYC_MIN(`T_RC_NS)
`define C_PAGE     `CYC_MIN(`T_AA_NS)
`define C_SETUP    `CYC_MIN(`T_CLOL_NS)
`define C_WP       `CYC_MIN(`T_AS_SUM_NS)
`define C_WR       `CYC_MIN(`T_WR_NS)
`define C_OHCL     `CYC_MIN(`T_OHCL_NS)
`define C_CSP      `CYC_MIN(`T_CSP_NS)
`define C_C2LP     `CYC_MIN(`T_C2LP_NS)
`define C_CHS      `CYC_MIN(`T_CHS_NS)
`define C_CHOX     `CYC_MIN(`T_CHOX_NS)
`define C_CHH_DEF  ((`T_CHH_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/psram_wait_timer.v
// down-counting interval timer for the access sequencer
// assumes the caller loads a count and watches o_done each cycle
`timescale 1ns/1ps
module psram_wait_timer (
  input  wire        i_clk,    // controller clock
  input  wire        i_reset,  // synchronous, active high
  input  wire        i_load,   // load a new count
  input  wire [13:0] i_count,  // cycles to wait, at least one
  output reg         o_done    // high once the count has run out
);
  reg [13:0] cnt_q;  // remaining cycles

  // load, then count to zero; done is a flop so the caller sees it clean
  always @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q  <= 14'h0000;
      o_done <= 1'b1;
    end else if (i_load) begin
      cnt_q  <= i_count - 14'h0001;
      o_done <= (i_count <= 14'h0001);
    end else if (cnt_q != 14'h0000) begin
      cnt_q  <= cnt_q - 14'h0001;
      o_done <= (cnt_q == 14'h0001);
    end else begin
      o_done <= 1'b1;
    end
  end
endmodule // psram_wait_timer

// File: core/psram_host_ctrl.v
// host controller driving a pseudo-static ram over its asynchronous pins
// assumes a 20 MHz clock, synchronous inputs, one request at a time
`timescale 1ns/1ps
`include "psram_host_map.vh"
module psram_host_ctrl #(
  parameter [13:0] CHH_CYC = `C_CHH_DEF  // select-high wait after wake
) (
  input  wire        i_clk,        // controller clock
  input  wire        i_reset,      // synchronous, active high
  input  wire        i_req,        // request pulse, taken when o_ready; only a wake is taken while asleep
  input  wire [1:0]  i_op,         // 0 read, 1 write, 2 sleep, 3 wake
  input  wire [19:0] i_addr,       // word address
  input  wire [15:0] i_wdata,      // write data
  input  wire [1:0]  i_be,         // byte enables, bit1 upper
  input  wire [3:0]  i_page_len,   // extra page words after first read
  input  wire [15:0] i_dq_in,      // data pins as seen by host
  output reg         o_ready,      // idle and able to take a request
  output reg         o_rvalid,     // one-cycle pulse with read data
  output reg  [15:0] o_rdata,      // read data
  output reg  [19:0] o_addr,       // address pins
  output reg         o_cs_n,       // primary_chip_select, low active
  output reg         o_sleep_n,    // sleep_control_pin, low is power-down
  output reg         o_oe_n,       // output enable, low active
  output reg         o_we_n,       // write enable, low active
  output reg         o_lb_n,       // lower_byte_lane, low active
  output reg         o_ub_n,       // upper_byte_lane, low active
  output reg  [15:0] o_dq_out,     // data driven on writes
  output reg         o_dq_oe       // high while host drives data
);
  localparam [3:0] S_IDLE  = 4'h0;  // waiting for a request
  localparam [3:0] S_RSET  = 4'h1;  // select low, output enable high
  localparam [3:0] S_RSTB  = 4'h2;  // output enable low, access running
  localparam [3:0] S_PAGE  = 4'h3;  // next page word, low bits moved
  localparam [3:0] S_RREC  = 4'h4;  // all high, standby recovery
  localparam [3:0] S_WSET  = 4'h5;  // select low, oe high, we high
  localparam [3:0] S_WSTB  = 4'h6;  // write enable low
  localparam [3:0] S_WREC  = 4'h7;  // strobes high, recovery
  localparam [3:0] S_SSET  = 4'h8;  // select high before sleep pin
  localparam [3:0] S_SLOW  = 4'h9;  // sleep pin held low
  localparam [3:0] S_ASLP  = 4'hA;  // asleep
  localparam [3:0] S_WAKE  = 4'hB;  // waking, select held high

  localparam [1:0] OP_RD = 2'h0;  // read
  localparam [1:0] OP_WR = 2'h1;  // write
  localparam [1:0] OP_SL = 2'h2;  // enter power-down
  localparam [1:0] OP_WK = 2'h3;  // leave power-down

  reg  [3:0]  st_q;       // sequencer state
  reg  [3:0]  left_q;     // page words still to fetch
  reg         ld;         // timer load
  reg  [13:0] ld_cnt;     // timer count
  wire        tdone;      // timer expired

  // cycle count of a minimum time, rounded up, at least one
  function [13:0] cyc;
    input integer ns;
    integer full;  // unclipped count; every figure fits fourteen bits
    begin
      full = `CYC_MIN(ns);
      cyc  = full[13:0];
    end
  endfunction

  psram_wait_timer u_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_load  (ld),
    .i_count (ld_cnt),
    .o_done  (tdone)
  );

  // timer loads on every state entry except S_IDLE and S_ASLP; each phase has its own interval
  always @* begin
    ld     = 1'b0;
    ld_cnt = 14'h0001;
    case (st_q)
      S_IDLE: begin
        if (i_req && o_ready) begin
          ld = 1'b1;
          case (i_op)
            OP_RD: ld_cnt = cyc(`T_CLOL_NS);
            OP_WR: ld_cnt = cyc(`T_OHCL_NS);
            OP_SL: ld_cnt = cyc(`T_CSP_NS);
            default: ld_cnt = cyc(`T_CHS_NS);
          endcase
        end
      end
      S_RSET: begin
        if (tdone) begin
          ld     = 1'b1;
          ld_cnt = cyc(`T_RC_NS);
        end
      end
      S_RSTB, S_PAGE: begin
        if (tdone) begin
          ld     = 1'b1;
          ld_cnt = (left_q != 4'h0) ? cyc(`T_AA_NS) : cyc(`T_CHOX_NS);
        end
      end
      S_WSET: begin
        if (tdone) begin
          ld     = 1'b1;
          ld_cnt = cyc(`T_AS_SUM_NS);
        end
      end
      S_WSTB: begin
        if (tdone) begin
          ld     = 1'b1;
          ld_cnt = cyc(`T_WR_NS);
        end
      end
      S_SSET: begin
        if (tdone) begin
          ld     = 1'b1;
          ld_cnt = cyc(`T_C2LP_NS);
        end
      end
      S_ASLP: begin
        if (i_req && i_op == OP_WK) begin
          ld     = 1'b1;
          ld_cnt = cyc(`T_CHS_NS);
        end
      end
      S_SLOW: begin
        if (tdone) begin
          ld     = 1'b0;
          ld_cnt = 14'h0001;
        end
      end
      S_WAKE: begin
        ld     = 1'b0;
        ld_cnt = 14'h0001;
      end
      default: begin
        ld     = 1'b0;
        ld_cnt = 14'h0001;
      end
    endcase
  end

  reg        wake_hi_q;  // sleep pin already raised during wake-up
  reg [13:0] chh_q;      // cycles of select high left after wake

  // sequencer and pin drivers; every pin is a flop
  always @(posedge i_clk) begin
    if (i_reset) begin
      st_q      <= S_IDLE;
      left_q    <= 4'h0;
      wake_hi_q <= 1'b0;
      o_ready   <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 16'h0000;
      o_addr    <= 20'h00000;
      o_cs_n    <= 1'b1;
      o_sleep_n <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_lb_n    <= 1'b1;
      o_ub_n    <= 1'b1;
      o_dq_out  <= 16'h0000;
      o_dq_oe   <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (i_req && o_ready) begin
            o_ready <= 1'b0;
            o_addr  <= i_addr;
            case (i_op)
              OP_RD: begin
                // select first, enable later: no device-side lengthening
                o_cs_n <= 1'b0;
                o_lb_n <= 1'b0;  // both lanes on reads
                o_ub_n <= 1'b0;
                left_q <= i_page_len;
                st_q   <= S_RSET;
              end
              OP_WR: begin
                // oe stays high across select fall so this is a write
                o_cs_n   <= 1'b0;
                o_lb_n   <= ~i_be[0];
                o_ub_n   <= ~i_be[1];
                o_dq_out <= i_wdata;
                o_dq_oe  <= 1'b1;
                st_q     <= S_WSET;
              end
              OP_SL: st_q <= S_SSET;  // select already high
              default: begin
                o_ready <= 1'b1;  // wake while awake: nothing to do
              end
            endcase
          end
        end
        S_RSET: begin
          if (tdone) begin
            o_oe_n <= 1'b0;
            st_q   <= S_RSTB;
          end
        end
        S_RSTB, S_PAGE: begin
          // first word sampled at a full read cycle, covering select and enable; page words at the page access time
          if (tdone) begin
            o_rdata  <= i_dq_in;
            o_rvalid <= 1'b1;
            if (left_q != 4'h0) begin
              // only the three low word bits move inside a page
              o_addr[2:0] <= o_addr[2:0] + 3'h1;
              left_q      <= left_q - 4'h1;
              st_q        <= S_PAGE;
            end else begin
              o_oe_n <= 1'b1;
              o_cs_n <= 1'b1;
              o_lb_n <= 1'b1;
              o_ub_n <= 1'b1;
              st_q   <= S_RREC;
            end
          end
        end
        S_RREC: begin
          if (tdone) begin
            o_ready <= 1'b1;
            st_q    <= S_IDLE;
          end
        end
        S_WSET: begin
          if (tdone) begin
            o_we_n <= 1'b0;
            st_q   <= S_WSTB;
          end
        end
        S_WSTB: begin
          // address and data stay until both strobes are high
          if (tdone) begin
            o_we_n <= 1'b1;
            o_cs_n <= 1'b1;
            st_q   <= S_WREC;
          end
        end
        S_WREC: begin
          // 60 + 20 ns rounds to three cycles, above the 80 ns write cycle
          if (tdone) begin
            o_dq_oe <= 1'b0;
            o_lb_n  <= 1'b1;
            o_ub_n  <= 1'b1;
            o_ready <= 1'b1;
            st_q    <= S_IDLE;
          end
        end
        S_SSET: begin
          if (tdone) begin
            o_sleep_n <= 1'b0;
            st_q      <= S_SLOW;
          end
        end
        S_SLOW: begin
          if (tdone) begin
            o_ready <= 1'b1;
            st_q    <= S_ASLP;
          end
        end
        S_ASLP: begin
          // only a wake request is accepted while asleep
          if (i_req && i_op == OP_WK) begin
            o_ready   <= 1'b0;
            wake_hi_q <= 1'b0;
            st_q      <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (tdone && !wake_hi_q) begin
            o_sleep_n <= 1'b1;
            wake_hi_q <= 1'b1;
          end else if (wake_hi_q && chh_q == 14'h0000) begin
            // no access until select has stood high the full wake wait
            o_ready <= 1'b1;
            st_q    <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // long select-high wait reuses the timer width via a separate counter
  always @(posedge i_clk) begin
    if (i_reset) begin
      chh_q <= 14'h0000;
    end else if (st_q == S_WAKE && tdone && !wake_hi_q) begin
      chh_q <= CHH_CYC;
    end else if (chh_q != 14'h0000) begin
      chh_q <= chh_q - 14'h0001;
    end
  end
endmodule // psram_host_ctrl

// File: bench/psram_host_monitor.sv
// pin-level checker for the host pseudo-static ram controller
// assumes it is bound onto psram_host_ctrl, one clock domain
`timescale 1ns/1ps
module psram_host_monitor (
  input wire        i_clk,     // controller clock
  input wire        i_reset,   // synchronous, active high
  input wire        o_ready,   // idle flag
  input wire        o_rvalid,  // read data strobe
  input wire [19:0] o_addr,    // address pins
  input wire        o_cs_n,    // primary_chip_select
  input wire        o_sleep_n, // sleep_control_pin
  input wire        o_oe_n,    // output enable
  input wire        o_we_n,    // write enable
  input wire        o_lb_n,    // lower_byte_lane
  input wire        o_ub_n     // upper_byte_lane
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // two cycles of strobe cover the 60 ns setup-plus-pulse sum
  sequence s_wpulse;
    !o_we_n ##1 !o_we_n;
  endsequence
  // sleep pin held low over two cycles, 100 ns
  sequence s_sleep_hold;
    !o_sleep_n ##1 !o_sleep_n;
  endsequence
  a_read_pins: assert property (!o_cs_n && !o_oe_n |->
    o_we_n && o_sleep_n && !(o_lb_n && o_ub_n)) else $error("read pins");
  a_oe_after_cs: assert property ($fell(o_oe_n) |->
    !o_cs_n && !$past(o_cs_n)) else $error("enable before select");
  a_page_bits: assert property (!o_cs_n && !o_oe_n && !$past(o_cs_n) &&
    !$past(o_oe_n) |-> o_addr[19:3] == $past(o_addr[19:3]))
    else $error("page moved high bits");
  a_read_sample: assert property (o_rvalid |->
    !$past(o_oe_n) && $past(o_addr) == $past(o_addr, 2))
    else $error("read sampled early");
  a_read_answer: assert property ($fell(o_oe_n) |-> ##[2:3] o_rvalid)
    else $error("read data late");
  a_write_oe: assert property (!o_we_n |-> o_oe_n && o_sleep_n)
    else $error("write with enable low");
  a_we_pulse: assert property ($fell(o_we_n) |-> s_wpulse)
    else $error("write pulse short");
  a_we_setup: assert property ($fell(o_we_n) |-> !$past(o_cs_n))
    else $error("select setup short");
  a_waddr_hold: assert property (!o_we_n && !$past(o_we_n) |->
    $stable(o_addr)) else $error("write address moved");
  a_cs_recover: assert property ($rose(o_cs_n) |=> o_cs_n)
    else $error("recovery short");
  a_sleep_entry: assert property ($fell(o_sleep_n) |->
    o_cs_n && $past(o_cs_n) ##0 s_sleep_hold) else $error("sleep entry");
  a_wake_cs: assert property ($rose(o_sleep_n) |->
    o_cs_n && $past(o_cs_n)) else $error("wake with select low");
  a_idle_pins: assert property (o_ready |->
    o_cs_n && o_we_n && o_oe_n) else $error("idle with strobes low");
endmodule // psram_host_monitor
bind psram_host_ctrl psram_host_monitor mon_u (.i_clk(i_clk),
  .i_reset(i_reset), .o_ready(o_ready), .o_rvalid(o_rvalid),
  .o_addr(o_addr), .o_cs_n(o_cs_n), .o_sleep_n(o_sleep_n),
  .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_lb_n(o_lb_n), .o_ub_n(o_ub_n));

// File: bench/psram_dev_model.sv
// behavioural pseudo-static ram as seen at its pins
// assumes host pins only; there is no clock on this side
`timescale 1ns/1ps
module psram_dev_model (
  input  wire [19:0] i_addr,    // address pins
  input  wire        i_cs_n,    // primary_chip_select
  input  wire        i_sleep_n, // sleep_control_pin
  input  wire        i_oe_n,    // output enable
  input  wire        i_we_n,    // write enable
  input  wire        i_lb_n,    // lower_byte_lane
  input  wire        i_ub_n,    // upper_byte_lane
  input  wire [15:0] i_dq,      // data driven by the host
  output wire [15:0] o_dq       // data seen by the host
);
  reg  [15:0] mem [0:255]; // folded array, low address bits only
  reg  [15:0] q;           // last word put on the bus
  reg  [1:0]  lanes;       // lanes taken at the strobe fall
  reg         armed;       // write accepted at the strobe fall
  wire        rd;          // read access in progress
  integer     k;           // fill index
  assign rd = !i_cs_n && !i_oe_n && i_we_n && i_sleep_n;
  initial begin
    for (k = 0; k < 256; k = k + 1) mem[k] = 16'h0000;
    q = 16'h0000;
    armed = 1'b0;
  end
  // data follows select, enable and page bits
  always @* if (rd) q = mem[i_addr[7:0]];
  // a released bus shows the inverse so stale data never passes
  assign #35 o_dq = rd ? q : ~q;
  // strobe while output enable is low is not taken as a write
  always @(negedge i_we_n) begin
    armed = !i_cs_n && i_oe_n && i_sleep_n;
    lanes = {i_ub_n, i_lb_n};
  end
  // data lands at the rising strobe, lane by lane
  always @(posedge i_we_n) begin
    if (armed && !lanes[0]) mem[i_addr[7:0]][7:0] = i_dq[7:0];
    if (armed && !lanes[1]) mem[i_addr[7:0]][15:8] = i_dq[15:8];
    armed = 1'b0;
  end
endmodule // psram_dev_model

// File: bench/test_psram_host_ctrl.sv
// self-checking bench for the host pseudo-static ram controller
// assumes psram_dev_model on the pins and the monitor bound in
`timescale 1ns/1ps
module test_psram_host_ctrl;
  typedef struct packed {
    logic [1:0] op; logic [19:0] a; logic [15:0] d; logic [15:0] exp;
  } row_t;
  reg         i_clk, i_reset, i_req;     // clock, reset, request
  reg  [1:0]  i_op, i_be;                // operation, byte lanes
  reg  [19:0] i_addr;                    // request address
  reg  [15:0] i_wdata;                   // request data
  reg  [3:0]  i_page_len;                // extra page words
  wire [15:0] dq_in, dev_dq, o_rdata, o_dq_out; // data paths
  wire [19:0] o_addr;                    // address pins
  wire o_ready, o_rvalid, o_cs_n, o_sleep_n, o_oe_n, o_we_n; // strobes
  wire o_lb_n, o_ub_n, o_dq_oe;          // lanes, drive enable
  row_t       rows [0:7];                // ordinary cases
  integer     n_errors, tests_run, r;    // counters, row index
  assign dq_in = o_dq_oe ? o_dq_out : dev_dq; // host wins when driving
  psram_host_ctrl #(.CHH_CYC(14'd4)) dut_u (.i_clk(i_clk),
    .i_reset(i_reset), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_be(i_be), .i_page_len(i_page_len),
    .i_dq_in(dq_in), .o_ready(o_ready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_addr(o_addr), .o_cs_n(o_cs_n),
    .o_sleep_n(o_sleep_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_lb_n(o_lb_n), .o_ub_n(o_ub_n), .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe));
  psram_dev_model dev_u (.i_addr(o_addr), .i_cs_n(o_cs_n),
    .i_sleep_n(o_sleep_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_lb_n(o_lb_n), .i_ub_n(o_ub_n), .i_dq(o_dq_out), .o_dq(dev_dq));
  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // a hang counts as a mismatch and closes the run
  initial begin
    #400000;
    n_errors = n_errors + 1;
    stop_test;
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // one request pulse once the controller is idle
  task issue(input [1:0] op, input [19:0] a, input [15:0] d,
             input [1:0] be, input [3:0] pl);
    integer n;
    begin
      n = 0;
      @(negedge i_clk);
      while (o_ready !== 1'b1 && n < 50) begin
        @(negedge i_clk);
        n = n + 1;
      end
      check({15'h0000, o_ready}, 16'h0001);
      @(posedge i_clk);
      i_req <= 1'b1;
      i_op <= op;
      i_addr <= a;
      i_wdata <= d;
      i_be <= be;
      i_page_len <= pl;
      @(posedge i_clk);
      i_req <= 1'b0;
    end
  endtask
  // wait a bounded time for one read word
  task take(input [15:0] exp);
    integer n;
    begin
      n = 0;
      @(negedge i_clk);
      while (o_rvalid !== 1'b1 && n < 20) begin
        @(negedge i_clk);
        n = n + 1;
      end
      check({15'h0000, o_rvalid}, 16'h0001);
      check(o_rdata, exp);
    end
  endtask
  task chk_idle;
    check({10'h000, o_ready, o_cs_n, o_oe_n, o_we_n, o_sleep_n, o_dq_oe},
          16'h003E);
  endtask
  task stop_test;
    begin
      if (n_errors == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    i_reset = 1'b1;
    i_req = 1'b0;
    i_op = 2'd0;
    i_be = 2'b11;
    i_addr = 20'h00000;
    i_wdata = 16'h0000;
    i_page_len = 4'h0;
    // writes, two lane-only writes, then reads back
    rows[0] = '{2'd1, 20'h00010, 16'h1234, 16'h0000};
    rows[1] = '{2'd1, 20'h00011, 16'hABCD, 16'h0000};
    rows[2] = '{2'd1, 20'h00017, 16'h5A5A, 16'h0000};
    rows[3] = '{2'd1, 20'h00011, 16'h7700, 16'h0000};
    rows[4] = '{2'd0, 20'h00010, 16'h0000, 16'h1234};
    rows[5] = '{2'd0, 20'h00011, 16'h0000, 16'h77CD};
    rows[6] = '{2'd0, 20'h00017, 16'h0000, 16'h5A5A};
    rows[7] = '{2'd0, 20'h00012, 16'h0000, 16'h0000};
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk_idle;
    for (r = 0; r < 8; r = r + 1) begin
      issue(rows[r].op, rows[r].a, rows[r].d, {r != 1, r != 3}, 4'h0);
      if (rows[r].op == 2'd0) take(rows[r].exp);
    end
    // page read wraps inside its eight-word group
    issue(2'd0, 20'h00016, 16'h0000, 2'b11, 4'h3);
    take(16'h0000);
    take(16'h5A5A);
    take(16'h1234);
    take(16'h77CD);
    // sleep, a refused read, then wake and read again
    issue(2'd2, 20'h00000, 16'h0000, 2'b11, 4'h0);
    issue(2'd0, 20'h00010, 16'h0000, 2'b11, 4'h0);
    repeat (6) begin
      @(negedge i_clk);
      check({14'h0000, o_cs_n, o_sleep_n}, 16'h0002);
    end
    issue(2'd3, 20'h00000, 16'h0000, 2'b11, 4'h0);
    repeat (3) @(negedge i_clk);
    check({15'h0000, o_sleep_n}, 16'h0001);
    check({15'h0000, o_ready}, 16'h0000);
    issue(2'd0, 20'h00010, 16'h0000, 2'b11, 4'h0);
    take(16'h1234);
    // reset in the middle of a write leaves the pins idle
    issue(2'd1, 20'h00012, 16'hFFFF, 2'b11, 4'h0);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk_idle;
    check(o_addr[15:0], 16'h0000);
    issue(2'd0, 20'h00011, 16'h0000, 2'b11, 4'h0);
    take(16'h77CD);
    stop_test;
  end
endmodule // test_psram_host_ctrl
